// [core/arf_params.svh]
`ifndef ARF_PARAMS_SVH
`define ARF_PARAMS_SVH

// ==========================================================
// Register offsets
`define ARF_ADDR_STATUS 8'h40
`define ARF_ADDR_CFG1 8'h4D
`define ARF_ADDR_IRQ_STATUS 8'h50
`define ARF_ADDR_IRQ_MASK 8'h51

// ==========================================================
// Reset values and write masks
`define ARF_CFG1_RESET 16'h0070
`define ARF_CFG1_WMASK 16'h03F8
`define ARF_IRQ_RESET 2'h0

// ==========================================================
// Field positions
`define ARF_GLOBAL_ALARM_FLAG_BIT 6
`define ARF_RATE_LSB 8
`define ARF_RATE_MSB 9
`define ARF_CHDEPTH_LSB 5
`define ARF_CHDEPTH_MSB 7
`define ARF_TMDEPTH_LSB 3
`define ARF_TMDEPTH_MSB 4
`define ARF_IRQ_CHAN_BIT 0
`define ARF_IRQ_TEMP_BIT 1

// ==========================================================
// Sizes
`define ARF_NUM_CHAN 4
`define ARF_NUM_TEMP 2
`define ARF_NUM_ALARM 6

// ==========================================================
// Timing: full conversion rate and the clock it is divided from
`define ARF_CLK_HZ 100000000
`define ARF_ADC_FULL_SPS 500000
`define ARF_ADC_BASE_CYCLES (`ARF_CLK_HZ / `ARF_ADC_FULL_SPS)

`endif

// [core/arf_pkg.sv]
`default_nettype none
`include "arf_params.svh"

package arf_pkg;

   // ==========================================================
   // Types
   typedef logic [15:0] arf_word_t;
   typedef logic [8:0] arf_depth_t;
   typedef logic [10:0] arf_div_t;

   typedef enum logic [1:0] {
      ARF_RATE_FULL,
      ARF_RATE_HALF,
      ARF_RATE_QUARTER,
      ARF_RATE_EIGHTH
   } arf_rate_e;

   // ==========================================================
   // Channel filter code to sample count
   function automatic arf_depth_t arf_chan_depth(input logic [2:0] code);
      case (code)
         3'h0: arf_chan_depth = 9'h001;
         3'h1: arf_chan_depth = 9'h004;
         3'h2: arf_chan_depth = 9'h008;
         3'h3: arf_chan_depth = 9'h010;
         3'h4: arf_chan_depth = 9'h020;
         3'h5: arf_chan_depth = 9'h040;
         3'h6: arf_chan_depth = 9'h080;
         default: arf_chan_depth = 9'h100;
      endcase
   endfunction

   // Temperature filter code to sample count
   function automatic arf_depth_t arf_temp_depth(input logic [1:0] code);
      case (code)
         2'h0: arf_temp_depth = 9'h001;
         2'h1: arf_temp_depth = 9'h002;
         2'h2: arf_temp_depth = 9'h004;
         default: arf_temp_depth = 9'h008;
      endcase
   endfunction

   // Rate code to clock cycles per conversion
   function automatic arf_div_t arf_rate_cycles(input arf_rate_e rate);
      arf_div_t base;
      base = 11'(`ARF_ADC_BASE_CYCLES);
      case (rate)
         ARF_RATE_FULL: arf_rate_cycles = base;
         ARF_RATE_HALF: arf_rate_cycles = 11'(base << 1);
         ARF_RATE_QUARTER: arf_rate_cycles = 11'(base << 2);
         default: arf_rate_cycles = 11'(base << 3);
      endcase
   endfunction

endpackage

`default_nettype wire

// [core/arf_filter.sv]
`default_nettype none

// ==========================================================
// Consecutive out-of-range counter for one alarm source
module arf_filter (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Asynchronous reset, active high
   input wire logic sample_i, // One-cycle strobe, a new sample
   input wire logic oor_i, // Sample is out of range
   input wire arf_pkg::arf_depth_t need_i, // Samples needed in a row
   output logic hit_o // Pulse, run length reached
);
   import arf_pkg::*;

   arf_depth_t count;
   arf_depth_t next_count;
   logic next_hit;

   // Run length bookkeeping; an in-range sample restarts the run
   always_comb begin
      next_count = count;
      next_hit = 1'b0;
      if (sample_i) begin
         if (!oor_i) begin
            next_count = 9'h000; // RQ11
         end else if (9'(count + 9'h001) >= need_i) begin
            next_count = need_i; // RQ9 RQ10
            next_hit = 1'b1;
         end else begin
            next_count = 9'(count + 9'h001); // RQ11
         end
      end
   end

   // Counter and hit register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count <= 9'h000;
         hit_o <= 1'b0;
      end else begin
         count <= next_count;
         hit_o <= next_hit;
      end
   end

endmodule

`default_nettype wire

// [core/arf_top.sv]
// Behaviour
// [RQ1] The global alarm flag in status bit 6 is the OR of all individual alarm bits of the status register.
// [RQ2] The global alarm flag sets on any alarm and stays set until the status register is read, which clears it.
// [RQ3] Reserved bits ignore writes and read as zero: status bits 5..0, configuration bits 15..10 and 2..0.
// [RQ4] The configuration register is read-write at address 4Dh and resets to 0070h.
// [RQ5] Configuration bits 9..8 are the read-write conversion rate field, reset to zero.
// [RQ6] Rate code 00 runs the converter at 500 kSPS, 01 at a half, 10 at a quarter, 11 at an eighth of it.
// [RQ7] Configuration bits 7..5 set the channel 0..3 alarm filter depth, reset to 011.
// [RQ8] Configuration bits 4..3 set the temperature alarm filter depth, reset to 10.
// [RQ9] Channel depth codes 000..111 need 1, 4, 8, 16, 32, 64, 128 or 256 out-of-range samples in a row.
// [RQ10] Temperature depth codes 00..11 need 1, 2, 4 or 8 out-of-range samples in a row.
// [RQ11] Every alarm source has its own run counter, restarted by any in-range sample.
//
// Strobed register access was left to the implementer.
`default_nettype none
`include "arf_params.svh"

module arf_top (
   input wire logic clk_i, // Clock, 100 MHz
   input wire logic rst_i, // Asynchronous reset, active high
   input wire logic [7:0] reg_addr_i, // Register address
   input wire arf_pkg::arf_word_t reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output arf_pkg::arf_word_t reg_rdata_o, // Read data, cycle after strobe
   input wire logic [3:0] chan_sample_i, // Channel sample strobes
   input wire logic [3:0] chan_oor_i, // Channel sample out of range
   input wire logic [1:0] temp_sample_i, // Temperature sample strobes
   input wire logic [1:0] temp_oor_i, // Temperature sample out of range
   output logic adc_conv_o, // Conversion start pulse
   output logic [1:0] adc_rate_select_o, // Current rate code
   output logic [2:0] chan_false_alarm_depth_o, // Current channel depth code
   output logic [1:0] temp_false_alarm_depth_o, // Current temperature depth code
   output logic [5:0] alarm_bits_o, // Latched individual alarms
   output logic global_alarm_flag_o, // Global alarm flag
   output logic irq_o // Interrupt, level, active high
);
   import arf_pkg::*;

   // ==========================================================
   // Declarations
   arf_word_t cfg1;
   logic [5:0] alarm_bits;
   logic global_alarm_flag;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   arf_div_t conv_count;
   arf_rate_e rate_sel;
   arf_depth_t chan_need;
   arf_depth_t temp_need;
   arf_div_t conv_limit;
   logic [3:0] chan_hit;
   logic [1:0] temp_hit;
   logic [5:0] all_hit;
   logic [5:0] next_alarm_bits;
   logic [1:0] irq_event;
   logic [1:0] next_irq_status;
   logic status_read;
   logic cfg1_write;
   logic irq_status_write;
   logic irq_mask_write;
   arf_word_t next_rdata;

   // ==========================================================
   // Address decode
   always_comb begin
      status_read = reg_rd_i && (reg_addr_i == `ARF_ADDR_STATUS);
      cfg1_write = reg_wr_i && (reg_addr_i == `ARF_ADDR_CFG1);
      irq_status_write = reg_wr_i && (reg_addr_i == `ARF_ADDR_IRQ_STATUS);
      irq_mask_write = reg_wr_i && (reg_addr_i == `ARF_ADDR_IRQ_MASK);
   end

   // ==========================================================
   // Configuration register
   // Only the rate and depth fields take write data; reserved bits stay zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg1 <= `ARF_CFG1_RESET; // RQ4 RQ5 RQ7 RQ8
      end else if (cfg1_write) begin
         cfg1 <= reg_wdata_i & `ARF_CFG1_WMASK; // RQ3 RQ4
      end
   end

   // Field extraction
   always_comb begin
      rate_sel = arf_rate_e'(cfg1[`ARF_RATE_MSB:`ARF_RATE_LSB]); // RQ5
      chan_need = arf_chan_depth(cfg1[`ARF_CHDEPTH_MSB:`ARF_CHDEPTH_LSB]); // RQ7 RQ9
      temp_need = arf_temp_depth(cfg1[`ARF_TMDEPTH_MSB:`ARF_TMDEPTH_LSB]); // RQ8 RQ10
      conv_limit = arf_rate_cycles(rate_sel); // RQ6
   end

   // Field outputs come straight from the register
   assign adc_rate_select_o = cfg1[`ARF_RATE_MSB:`ARF_RATE_LSB];
   assign chan_false_alarm_depth_o = cfg1[`ARF_CHDEPTH_MSB:`ARF_CHDEPTH_LSB];
   assign temp_false_alarm_depth_o = cfg1[`ARF_TMDEPTH_MSB:`ARF_TMDEPTH_LSB];

   // ==========================================================
   // Conversion rate divider
   // A pulse every 200, 400, 800 or 1600 cycles; the compare is
   // greater-or-equal so a rate change mid-period cannot overrun
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_count <= 11'h000;
         adc_conv_o <= 1'b0;
      end else if (11'(conv_count + 11'h001) >= conv_limit) begin
         conv_count <= 11'h000; // RQ6
         adc_conv_o <= 1'b1;
      end else begin
         conv_count <= 11'(conv_count + 11'h001);
         adc_conv_o <= 1'b0;
      end
   end

   // ==========================================================
   // Alarm filters, one per source
   genvar gi;
   generate
      for (gi = 0; gi < `ARF_NUM_CHAN; gi = gi + 1) begin : g_chan
         // Channel source filter
         arf_filter u_filter (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .sample_i(chan_sample_i[gi]),
            .oor_i(chan_oor_i[gi]),
            .need_i(chan_need),
            .hit_o(chan_hit[gi])
         ); // RQ11
      end
      for (gi = 0; gi < `ARF_NUM_TEMP; gi = gi + 1) begin : g_temp
         // Temperature source filter
         arf_filter u_filter (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .sample_i(temp_sample_i[gi]),
            .oor_i(temp_oor_i[gi]),
            .need_i(temp_need),
            .hit_o(temp_hit[gi])
         ); // RQ11
      end
   endgenerate

   // ==========================================================
   // Latched alarms and global flag
   // A status read clears everything, but a hit in the same cycle wins
   always_comb begin
      all_hit = {temp_hit, chan_hit};
      if (status_read) begin
         next_alarm_bits = all_hit; // RQ2
      end else begin
         next_alarm_bits = alarm_bits | all_hit; // RQ2
      end
   end

   // Alarm bit and flag registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         alarm_bits <= 6'h00;
         global_alarm_flag <= 1'b0;
      end else begin
         alarm_bits <= next_alarm_bits;
         global_alarm_flag <= |next_alarm_bits; // RQ1 RQ2
      end
   end

   assign alarm_bits_o = alarm_bits;
   assign global_alarm_flag_o = global_alarm_flag;

   // ==========================================================
   // Interrupt status and mask
   // Write one to clear; a new event in the same cycle keeps its bit
   always_comb begin
      irq_event[`ARF_IRQ_CHAN_BIT] = |chan_hit;
      irq_event[`ARF_IRQ_TEMP_BIT] = |temp_hit;
      next_irq_status = irq_status;
      if (irq_status_write) begin
         next_irq_status = irq_status & ~reg_wdata_i[1:0];
      end
      next_irq_status = next_irq_status | irq_event;
   end

   // Interrupt registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_status <= `ARF_IRQ_RESET;
         irq_mask <= `ARF_IRQ_RESET;
      end else begin
         irq_status <= next_irq_status;
         if (irq_mask_write) begin
            irq_mask <= reg_wdata_i[1:0];
         end
      end
   end

   assign irq_o = |(irq_status & irq_mask);

   // ==========================================================
   // Read path
   // Status shows only the flag; unmapped addresses read zero
   always_comb begin
      next_rdata = 16'h0000;
      case (reg_addr_i)
         `ARF_ADDR_STATUS: next_rdata[`ARF_GLOBAL_ALARM_FLAG_BIT] = global_alarm_flag; // RQ1 RQ3
         `ARF_ADDR_CFG1: next_rdata = cfg1; // RQ3 RQ4
         `ARF_ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
         `ARF_ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
         default: next_rdata = 16'h0000;
      endcase
   end

   // Read data register, valid the cycle after the strobe only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

endmodule

`default_nettype wire

// [testbench/arf_chk.sv]
`default_nettype none

// ==========================================================
// Port-level checks for the alarm filter register bank
module arf_chk (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic [7:0] reg_addr_i, // Address
   input wire arf_pkg::arf_word_t reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire arf_pkg::arf_word_t reg_rdata_o, // Read data
   input wire logic [3:0] chan_sample_i, // Channel strobes
   input wire logic [3:0] chan_oor_i, // Channel out of range
   input wire logic [1:0] temp_sample_i, // Temperature strobes
   input wire logic [1:0] temp_oor_i, // Temperature out of range
   input wire logic adc_conv_o, // Conversion pulse
   input wire logic [1:0] adc_rate_select_o, // Rate code
   input wire logic [2:0] chan_false_alarm_depth_o, // Channel depth
   input wire logic [1:0] temp_false_alarm_depth_o, // Temperature depth
   input wire logic [5:0] alarm_bits_o, // Alarm bits
   input wire logic global_alarm_flag_o // Global flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [11:0] gap;
   logic seen;
   logic chg;

   // Cycles since the last conversion pulse, skipping periods that saw a rate change
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap <= 12'h000;
         seen <= 1'b0;
         chg <= 1'b0;
      end else begin
         gap <= adc_conv_o ? 12'h001 : gap + 12'h001;
         seen <= seen | adc_conv_o;
         chg <= (adc_conv_o ? 1'b0 : chg) | $changed(adc_rate_select_o);
      end
   end

   sequence s_temp_hit;
      temp_sample_i[0] && temp_oor_i[0] && temp_false_alarm_depth_o == 2'h0;
   endsequence
   sequence s_status_rd;
      reg_rd_i && reg_addr_i == 8'h40;
   endsequence

   property p_flag_or;
      global_alarm_flag_o == (|alarm_bits_o);
   endproperty
   property p_rd_clear;
      s_status_rd ##0 ($past(chan_sample_i) == 4'h0 && $past(temp_sample_i) == 2'h0) |=> !global_alarm_flag_o;
   endproperty
   property p_flag_hold;
      global_alarm_flag_o && !(reg_rd_i && reg_addr_i == 8'h40) |=> global_alarm_flag_o;
   endproperty
   property p_status_data;
      s_status_rd |=> reg_rdata_o == {9'h000, $past(global_alarm_flag_o), 6'h00};
   endproperty
   property p_cfg_rd;
      reg_rd_i && reg_addr_i == 8'h4D |=> reg_rdata_o == {6'h00, $past(adc_rate_select_o),
         $past(chan_false_alarm_depth_o), $past(temp_false_alarm_depth_o), 3'h0};
   endproperty
   property p_cfg_wr;
      reg_wr_i && reg_addr_i == 8'h4D |=>
         {adc_rate_select_o, chan_false_alarm_depth_o, temp_false_alarm_depth_o} == $past(reg_wdata_i[9:3]);
   endproperty
   property p_conv_gap;
      adc_conv_o && seen && !chg |-> gap == (12'd200 << adc_rate_select_o);
   endproperty
   property p_conv_bound;
      gap <= 12'd1600;
   endproperty
   property p_temp_one;
      s_temp_hit |-> ##2 alarm_bits_o[4];
   endproperty
   property p_chan_one;
      chan_sample_i[0] && chan_oor_i[0] && chan_false_alarm_depth_o == 3'h0 |-> ##2 alarm_bits_o[0];
   endproperty

   a_flag_or: assert property (p_flag_or) else $error("flag differs from OR of alarm bits");
   a_rd_clear: assert property (p_rd_clear) else $error("status read left flag set");
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without status read");
   a_status_data: assert property (p_status_data) else $error("status read data wrong");
   a_cfg_rd: assert property (p_cfg_rd) else $error("config read data wrong");
   a_cfg_wr: assert property (p_cfg_wr) else $error("config fields not written");
   a_conv_gap: assert property (p_conv_gap) else $error("conversion period wrong");
   a_conv_bound: assert property (p_conv_bound) else $error("conversion pulse missing");
   a_temp_one: assert property (p_temp_one) else $error("temperature alarm late");
   a_chan_one: assert property (p_chan_one) else $error("channel alarm late");
endmodule

`default_nettype wire

// [testbench/arf_host.sv]
`default_nettype none

// ==========================================================
// Host side of the register port
module arf_host (
   input wire logic clk_i, // Clock
   output logic [7:0] reg_addr_o, // Address
   output arf_pkg::arf_word_t reg_wdata_o, // Write data
   output logic reg_wr_o, // Write strobe
   output logic reg_rd_o // Read strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   import arf_pkg::*;

   // Idle bus at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // One-cycle write, then one idle cycle
   task automatic wr(input logic [7:0] a, input arf_word_t d);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      @(posedge clk_i);
   endtask

   // One-cycle read strobe; data are collected by the bench monitor
   task automatic rd(input logic [7:0] a);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

// [testbench/tb.sv]
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import arf_pkg::*;
   logic clk_i, rst_i, reg_wr_i, reg_rd_i, adc_conv_o, global_alarm_flag_o, irq_o, rd_d;
   logic [7:0] reg_addr_i;
   arf_word_t reg_wdata_i, reg_rdata_o, w;
   logic [3:0] chan_sample_i, chan_oor_i;
   logic [1:0] temp_sample_i, temp_oor_i, adc_rate_select_o, temp_false_alarm_depth_o;
   logic [2:0] chan_false_alarm_depth_o;
   logic [5:0] alarm_bits_o;
   arf_word_t exp_q[$];
   logic [31:0] seed = 32'd70278;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   arf_host u_host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i));
   arf_top DUT (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .chan_sample_i,
      .chan_oor_i, .temp_sample_i, .temp_oor_i, .adc_conv_o, .adc_rate_select_o, .chan_false_alarm_depth_o,
      .temp_false_alarm_depth_o, .alarm_bits_o, .global_alarm_flag_o, .irq_o);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string n, input arf_word_t e, input arf_word_t g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask

   task automatic rd(input logic [7:0] a, input arf_word_t e);
      exp_q.push_back(e);
      u_host.rd(a);
   endtask

   // One sample strobe on a channel or temperature source
   task automatic smp(input bit t, input int i, input bit o);
      if (t) begin
         temp_sample_i[i] <= 1'b1;
         temp_oor_i[i] <= o;
      end else begin
         chan_sample_i[i] <= 1'b1;
         chan_oor_i[i] <= o;
      end
      @(posedge clk_i);
      chan_sample_i <= 4'h0;
      temp_sample_i <= 2'h0;
      @(posedge clk_i);
   endtask

   // Fresh start, a broken run, then an unbroken run of the needed length;
   // the first in-range sample drops a count saturated by an earlier depth
   task automatic filt(input bit t, input int i, input int need);
      smp(t, i, 1'b0);
      for (int k = 0; k < need - 1; k++) smp(t, i, 1'b1);
      smp(t, i, 1'b0);
      for (int k = 0; k < need - 1; k++) smp(t, i, 1'b1);
      @(posedge clk_i);
      chk("alarm before run end", 16'h0000, {10'h000, alarm_bits_o});
      smp(t, i, 1'b1);
      @(posedge clk_i);
      chk("alarm after run", 16'h0001 << (t ? 4 + i : i), {10'h000, alarm_bits_o});
      rd(8'h40, 16'h0040);
      rd(8'h40, 16'h0000);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // Clock, read monitor and timeout
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Read data stand in the cycle after the strobe; compare with the oldest note
   always @(posedge clk_i) begin
      rd_d <= reg_rd_i;
      cycles++;
      if (rd_d === 1'b1) chk("read data", exp_q.pop_front(), reg_rdata_o);
      if (cycles == 40000) begin
         err_count++;
         results();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      rst_i = 1'b1;
      chan_sample_i = 4'h0;
      chan_oor_i = 4'h0;
      temp_sample_i = 2'h0;
      temp_oor_i = 2'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h4D, 16'h0070);
      rd(8'h40, 16'h0000);
      rd(8'h51, 16'h0000);
      rd(8'h7F, 16'h0000);
      u_host.wr(8'h40, 16'hFFFF);
      rd(8'h40, 16'h0000);
      repeat (8) begin
         w = 16'(rnd());
         u_host.wr(8'h4D, w);
         rd(8'h4D, w & 16'h03F8);
      end
      $display("register test done");
      for (int r = 0; r < 4; r++) begin
         u_host.wr(8'h4D, 16'(r << 8));
         repeat (3 * (200 << r) + 10) @(posedge clk_i);
      end
      $display("rate test done");
      for (int c = 0; c < 8; c++) begin
         u_host.wr(8'h4D, 16'(c << 5));
         filt(1'b0, c % 4, c == 0 ? 1 : 2 << c);
      end
      for (int t = 0; t < 4; t++) begin
         u_host.wr(8'h4D, 16'(t << 3));
         filt(1'b1, t % 2, 1 << t);
      end
      $display("filter test done");
      @(posedge clk_i);
      chk("irq masked", 16'h0000, {15'h0000, irq_o});
      u_host.wr(8'h51, 16'h0003);
      @(posedge clk_i);
      chk("irq unmasked", 16'h0001, {15'h0000, irq_o});
      u_host.wr(8'h50, 16'h0003);
      @(posedge clk_i);
      chk("irq cleared", 16'h0000, {15'h0000, irq_o});
      rd(8'h50, 16'h0000);
      rd(8'h51, 16'h0003);
      $display("interrupt test done");
      repeat (2) @(posedge clk_i);
      results();
   end
endmodule

bind arf_top arf_chk u_chk (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .chan_sample_i, .chan_oor_i, .temp_sample_i, .temp_oor_i, .adc_conv_o, .adc_rate_select_o,
   .chan_false_alarm_depth_o, .temp_false_alarm_depth_o, .alarm_bits_o, .global_alarm_flag_o);

`default_nettype wire
